/* File: verilog/spd_pkg.sv */
// Purpose: shared constants and carrier types for the serial diagnostic port
// Assumes: core clock of 125 MHz
// Notes:   offsets, field positions and the filter count live here; the start-up cycle count is a parameter of spd_diag_port
package spd_pkg;

  // core clock rate
  localparam int CLK_MHZ             = 125;

  // frame layout
  localparam int FRAME_BITS          = 16;
  localparam int FRAME_RW_BIT        = 15;
  localparam int FRAME_ADDR_MSB      = 14;
  localparam int FRAME_ADDR_LSB      = 8;
  localparam int FRAME_DATA_MSB      = 7;
  localparam logic [3:0] BIT_MOD_ZERO = 4'h0;

  // register addresses
  localparam logic [6:0] ADDR_JUNCTION_TEMP = 7'h46;
  localparam logic [6:0] ADDR_FAULT_FLAGS   = 7'h5f;

  // fault status byte positions
  localparam int FLAG_OUT_ONE        = 7;
  localparam int FLAG_OUT_TWO        = 6;
  localparam int FLAG_GATE_GOOD      = 5;
  localparam int FLAG_OVERTEMP       = 4;
  localparam int FLAG_SUPPLY_LOW     = 3;
  localparam int FLAG_SUPPLY_HIGH    = 2;
  localparam int FLAG_SERIAL_ERR     = 1;
  localparam int FLAG_GATE_OVERLOAD  = 0;

  // temperature codes
  localparam logic [7:0] TEMP_CODE_MIN   = 8'h18;
  localparam logic [7:0] TEMP_CODE_LIMIT = 8'h82;

  // output regulation filter time
  localparam int FILTER_TIME_US      = 10;
  localparam int FILTER_CYCLES       = FILTER_TIME_US * CLK_MHZ;
  localparam int FILTER_CNT_W        = 12;

  // gate supply start-up error time
  localparam int STARTUP_ERR_TIME_US = 1000;
  localparam int STARTUP_CNT_W       = 20;

  // reset values
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  // one serial frame
  typedef struct packed {
    logic       rw;
    logic [6:0] addr;
    logic [7:0] data;
  } spd_frame_type;

  // sticky fault flags
  typedef struct packed {
    logic overtemp;
    logic supply_low;
    logic supply_high;
    logic serial_err;
    logic gate_overload;
  } spd_faults_type;

endpackage

/* File: verilog/spd_window_filter.sv */
// Purpose: debounce of one regulation window comparator
// Assumes: window input is on the core clock
// Notes:   flag follows the input only after it held the opposite level long enough; hold clear drops it at once
`timescale 1ns/1ps
module spd_window_filter
  import spd_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // window input and filtered flag
  input  wire logic in_window_i,
  input  wire logic hold_clear_i,
  output logic      regulated_o
);

  typedef struct packed {
    logic [FILTER_CNT_W-1:0] cnt;  // cycles of disagreement
    logic                    flag; // filtered level
  } spd_filter_type;

  spd_filter_type st;      // registered state
  spd_filter_type next_st; // next state

  // count while input disagrees with flag
  always_comb begin
    next_st = st;
    if (hold_clear_i) begin
      next_st.cnt  = '0;
      next_st.flag = 1'b0;
    end else if (in_window_i == st.flag) begin
      // agreement restarts the filter
      next_st.cnt = '0;
    end else if (st.cnt == FILTER_CNT_W'(FILTER_CYCLES)) begin
      next_st.flag = in_window_i;
      next_st.cnt  = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign regulated_o = st.flag;

endmodule

/* File: verilog/spd_diag_port.sv */
// Purpose: serial slave port with fault status and temperature readout
// Assumes: monitor inputs come from logic on clk_i; serial pins are asynchronous
// Notes:   serial pins pass two flops before use; edges found on the core clock
//
// Contract
// - temperature code readable at 0x46
// - fault status byte at 0x5F
// - write or off entry clears faults
// - fail silent persists after flag clear
// - overtemp sets flag and fail silent
// - late gate supply sets overload, fail
// - gate good lost after start-up fails
// - regulated set after filter time inside
// - regulated cleared after filter time outside
// - chip select low active, output floats
// - sample falling, change rising edge
// - frame: rw, address, data byte
// - reply: status, then previous result
// - first command after off returns zero
// - accept any multiple of 16 clocks
// - bad length discards write, flags error
// - reads ignore data, change nothing
// - invalid commands flagged and discarded
// - reserved or read-only access is error
// - after error modify nothing, zero data
// - fail silent stops gate drive
`timescale 1ns/1ps
module spd_diag_port
  import spd_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_ERR_TIME_US * CLK_MHZ
)(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // serial pins
  input  wire logic       sclk_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  // monitors
  input  wire logic       off_mode_i,
  input  wire logic [7:0] junction_temp_i,
  input  wire logic       supply_low_i,
  input  wire logic       supply_high_i,
  input  wire logic       gate_supply_window_i,
  input  wire logic [1:0] out_window_i,
  // status
  output logic            fail_silent_o,
  output logic            gate_drive_enable_o,
  output logic [7:0]      status_o
);

  typedef struct packed {
    logic [2:0]               cs_s;        // chip select sync chain
    logic [2:0]               sclk_s;      // serial clock sync chain
    logic [1:0]               sdi_s;       // data in sync chain
    logic [15:0]              rx;          // received bits
    logic [15:0]              tx;          // outgoing bits
    logic [3:0]               bit_mod;     // clocks modulo frame
    logic                     any_bit;     // at least one clock seen
    logic [7:0]               resp;        // result of last command
    spd_faults_type           faults;      // sticky faults
    logic                     gate_good;   // gate supply good
    logic                     fail_silent; // latched fail silent
    logic                     first_cmd;   // next frame replies zero
    logic                     started;     // start-up window over
    logic [STARTUP_CNT_W-1:0] start_cnt;   // start-up timer
    logic                     off_d;       // delayed off mode
  } spd_state_type;

  spd_state_type st;      // registered state
  spd_state_type next_st; // next state

  logic [1:0]    out_ok;      // filtered regulation flags
  logic [7:0]    status;      // live fault status byte
  logic [7:0]    cleared;     // status after a clearing write
  spd_frame_type frame;       // decoded last frame
  logic          cs_fall;     // frame start
  logic          cs_rise;     // frame end
  logic          sclk_rise;   // serial clock rising
  logic          sclk_fall;   // serial clock falling
  logic          len_ok;      // whole frames only
  logic          cmd_err;     // command rejected
  logic          wr_clr;      // valid write to status
  logic          rd_ok;       // valid read
  logic [7:0]    rd_data;     // read result
  logic          off_enter;   // off mode entered
  logic          overtemp_ev; // temperature limit reached

  // regulation filters, one per output
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filter
      spd_window_filter u_filter (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .in_window_i  (out_window_i[gi]),
        .hold_clear_i (off_mode_i),
        .regulated_o  (out_ok[gi])
      );
    end
  endgenerate

  // edge detection on synchronised pins
  assign cs_fall   = st.cs_s[2] & ~st.cs_s[1];
  assign cs_rise   = ~st.cs_s[2] & st.cs_s[1];
  assign sclk_rise = ~st.sclk_s[2] & st.sclk_s[1] & ~st.cs_s[2];
  assign sclk_fall = st.sclk_s[2] & ~st.sclk_s[1] & ~st.cs_s[2];
  assign off_enter = off_mode_i & ~st.off_d;
  assign frame     = st.rx;
  assign len_ok    = st.any_bit & (st.bit_mod == BIT_MOD_ZERO);
  assign overtemp_ev = ~off_mode_i & (junction_temp_i >= TEMP_CODE_LIMIT);

  // live status byte
  always_comb begin
    status                     = BYTE_ZERO;
    status[FLAG_OUT_ONE]       = out_ok[0];
    status[FLAG_OUT_TWO]       = out_ok[1];
    status[FLAG_GATE_GOOD]     = st.gate_good;
    status[FLAG_OVERTEMP]      = st.faults.overtemp;
    status[FLAG_SUPPLY_LOW]    = st.faults.supply_low;
    status[FLAG_SUPPLY_HIGH]   = st.faults.supply_high;
    status[FLAG_SERIAL_ERR]    = st.faults.serial_err;
    status[FLAG_GATE_OVERLOAD] = st.faults.gate_overload;
    // sticky bits drop, live bits stay
    cleared                    = BYTE_ZERO;
    cleared[FLAG_OUT_ONE]      = out_ok[0];
    cleared[FLAG_OUT_TWO]      = out_ok[1];
    cleared[FLAG_GATE_GOOD]    = st.gate_good;
  end

  // command decode at frame end
  always_comb begin
    rd_data = BYTE_ZERO;
    rd_ok   = 1'b0;
    wr_clr  = 1'b0;
    cmd_err = 1'b0;
    if (cs_rise) begin
      if (!len_ok) begin
        cmd_err = 1'b1;
      end else if (frame.rw) begin
        if (frame.addr == ADDR_JUNCTION_TEMP) begin
          rd_ok   = 1'b1;
          rd_data = junction_temp_i;
        end else if (frame.addr == ADDR_FAULT_FLAGS) begin
          rd_ok   = 1'b1;
          rd_data = status;
        end else begin
          cmd_err = 1'b1;
        end
      end else if (frame.addr == ADDR_FAULT_FLAGS) begin
        // any data value clears
        wr_clr = 1'b1;
      end else begin
        cmd_err = 1'b1;
      end
    end
  end

  // next state
  always_comb begin
    next_st = st;
    // synchronisers, first stage only feeds the second
    next_st.cs_s   = {st.cs_s[1], st.cs_s[0], chip_select_n_i};
    next_st.sclk_s = {st.sclk_s[1], st.sclk_s[0], sclk_i};
    next_st.sdi_s  = {st.sdi_s[0], sdi_i};
    next_st.off_d  = off_mode_i;

    // frame start loads reply
    if (cs_fall) begin
      next_st.bit_mod = BIT_MOD_ZERO;
      next_st.any_bit = 1'b0;
      if (st.first_cmd) begin
        next_st.tx        = WORD_ZERO;
        next_st.first_cmd = 1'b0;
      end else begin
        next_st.tx = {status, st.resp};
      end
    end
    if (sclk_fall) begin
      next_st.rx      = {st.rx[FRAME_BITS-2:0], st.sdi_s[1]};
      next_st.bit_mod = st.bit_mod + 1'b1;
      next_st.any_bit = 1'b1;
    end
    // bit 15 stays for first clock
    if (sclk_rise && st.any_bit) begin
      next_st.tx = {st.tx[FRAME_BITS-2:0], st.rx[0]};
    end

    // command result
    if (rd_ok) begin
      next_st.resp = rd_data;
    end else if (wr_clr) begin
      next_st.resp = cleared;
    end else if (cmd_err) begin
      next_st.resp = BYTE_ZERO;
    end

    if (wr_clr) begin
      next_st.faults = '0;
    end

    // gate supply supervision
    if (!st.started) begin
      next_st.start_cnt = st.start_cnt + 1'b1;
      if (gate_supply_window_i) begin
        next_st.started   = 1'b1;
        next_st.gate_good = 1'b1;
      end else if (st.start_cnt == STARTUP_CNT_W'(STARTUP_CYCLES - 1)) begin
        next_st.started              = 1'b1;
        next_st.faults.gate_overload = 1'b1;
        next_st.fail_silent          = 1'b1;
      end
    end else if (!gate_supply_window_i && st.gate_good) begin
      next_st.gate_good   = 1'b0;
      next_st.fail_silent = 1'b1;
    end

    // hardware sets win over clears
    if (overtemp_ev) begin
      next_st.faults.overtemp = 1'b1;
      next_st.fail_silent     = 1'b1;
    end
    if (supply_low_i && !off_mode_i) begin
      next_st.faults.supply_low = 1'b1;
      next_st.fail_silent       = 1'b1;
    end
    if (supply_high_i && !off_mode_i) begin
      next_st.faults.supply_high = 1'b1;
      next_st.fail_silent        = 1'b1;
    end
    if (cmd_err) begin
      next_st.faults.serial_err = 1'b1;
    end

    // off mode restarts supervision
    if (off_mode_i) begin
      next_st.started     = 1'b0;
      next_st.start_cnt   = '0;
      next_st.gate_good   = 1'b0;
      next_st.fail_silent = 1'b0;
      next_st.first_cmd   = 1'b1;
      next_st.resp        = BYTE_ZERO;
    end
    if (off_enter) begin
      next_st.faults = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st           <= '0;
      st.cs_s      <= 3'h7;
      st.first_cmd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // output drive
  // float while deselected
  assign sdo_oe_o = ~st.cs_s[2];
  assign sdo_o    = st.tx[FRAME_RW_BIT];
  assign status_o = status;
  assign fail_silent_o = st.fail_silent;
  assign gate_drive_enable_o = st.gate_good & ~st.fail_silent & ~off_mode_i;

  // checks
  chk_sdo_float: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    sdo_oe_o == !$past(chip_select_n_i, 3))
    else $error("serial output enable not following chip select");

  chk_fail_sticky: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (fail_silent_o && !off_mode_i) |=> fail_silent_o)
    else $error("fail silent left without off mode");

  chk_overtemp_set: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    overtemp_ev |=> (status_o[FLAG_OVERTEMP] && fail_silent_o))
    else $error("overtemp not flagged");

  chk_write_clear: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_clr && !supply_low_i && !supply_high_i) |=>
      !status_o[FLAG_SUPPLY_LOW] && !status_o[FLAG_SUPPLY_HIGH])
    else $error("status write did not clear supply flags");

  chk_bad_length: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cs_rise && !len_ok && !off_mode_i) |=>
      status_o[FLAG_SERIAL_ERR] && (st.resp == BYTE_ZERO))
    else $error("bad frame length not flagged");

  chk_first_zero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cs_fall && st.first_cmd) |=> (st.tx == WORD_ZERO))
    else $error("first reply after off not zero");

  chk_read_result: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_ok && !off_mode_i) |=> (st.resp == $past(rd_data)))
    else $error("read result not kept");

  chk_gate_stop: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    fail_silent_o |-> !gate_drive_enable_o)
    else $error("gate drive while fail silent");

  chk_gate_lost: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (st.started && st.gate_good && !gate_supply_window_i && !off_mode_i) |=>
      (!status_o[FLAG_GATE_GOOD] && fail_silent_o))
    else $error("gate supply loss not handled");

endmodule

/* File: testbench/spd_master_model.sv */
// Purpose: serial master driving frames into the diagnostic port
// Assumes: link clock period 125 ns, sample on falling edge
// Notes:   reply keeps the first 16 bits seen on the data line
`timescale 1ns/1ps
module spd_master_model (
  // serial pins
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // half link clock period
  localparam realtime HALF = 62.5;

  initial begin
    sclk_o          = 1'b0;
    chip_select_n_o = 1'b1;
    sdi_o           = 1'b0;
  end

  // one transaction of n clocks
  task automatic xfer(input logic [63:0] bits, input int n, output logic [15:0] reply);
    chip_select_n_o = 1'b0;
    #(2*HALF);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o  = bits[i];
      #HALF;
      sclk_o = 1'b0;
      if (n - 1 - i < 16) reply = {reply[14:0], sdo_i};
      #HALF;
    end
    chip_select_n_o = 1'b1;
    // released data line no longer shows last bit
    sdi_o = ~sdi_o;
    #(4*HALF);
  endtask
endmodule

/* File: testbench/spd_diag_port_tb.sv */
// Purpose: self-checking bench for the serial diagnostic port
// Assumes: start-up timer shortened to 50 cycles
// Notes:   table rows for frames, hand tests for monitors and off mode
`timescale 1ns/1ps
module spd_diag_port_tb;
  import spd_pkg::*;

  // one table row: bits, clock count, expected reply
  typedef struct packed {
    logic [31:0] bits;
    logic [5:0]  n;
    logic [15:0] exp;
  } spd_row_type;

  logic        clk, reset_n, sclk, cs_n, sdi, sdo, sdo_oe, sdo_last, sdo_line;
  logic        off_mode, sup_low, sup_high, gate_win, fail, gde;
  logic [7:0]  temp, status;
  logic [1:0]  out_win;
  logic [15:0] rep;
  int          err_total, tests_run;
  spd_row_type rows[12];

  // line floats when not driven: show inverse of last bit
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo;
  assign sdo_line = sdo_oe ? sdo : ~sdo_last;

  spd_diag_port #(.STARTUP_CYCLES(50)) dut (
    .clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk), .chip_select_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .off_mode_i(off_mode),
    .junction_temp_i(temp), .supply_low_i(sup_low), .supply_high_i(sup_high),
    .gate_supply_window_i(gate_win), .out_window_i(out_win),
    .fail_silent_o(fail), .gate_drive_enable_o(gde), .status_o(status));

  spd_master_model m (.sclk_o(sclk), .chip_select_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line));

  // core clock 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // watchdog for hangs
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    reset_n   = 1'b0;
    off_mode  = 1'b0;
    sup_low   = 1'b0;
    sup_high  = 1'b0;
    gate_win  = 1'b1;
    out_win   = 2'b11;
    temp      = 8'h50;
    rows = '{
      '{32'h0000_c600, 6'h10, 16'he0e0}, '{32'h0000_dfaa, 6'h10, 16'he050},
      '{32'h0000_4612, 6'h10, 16'he0e0}, '{32'h0000_c600, 6'h10, 16'he200},
      '{32'h0000_a000, 6'h10, 16'he250}, '{32'h0000_5f00, 6'h10, 16'he200},
      '{32'h0000_df00, 6'h10, 16'he0e0}, '{32'h1234_c600, 6'h20, 16'he0e0},
      '{32'h0000_c600, 6'h10, 16'he050}, '{32'h0000_5f00, 6'h11, 16'he050},
      '{32'h0000_c600, 6'h10, 16'he200}, '{32'h0000_5fff, 6'h10, 16'he250}};
    cyc(4);
    check("reset state", {6'h00, status, fail, sdo_oe}, 16'h0000);
    reset_n = 1'b1;
    cyc(1320);
    check("regulated", {7'h00, status, gde}, 16'h01c1);
    m.xfer({48'h0, 16'h5fff}, 16, rep);
    check("first reply", rep, 16'h0000);
    foreach (rows[i]) begin
      cyc(1);
      m.xfer({32'h0, rows[i].bits}, int'(rows[i].n), rep);
      check("frame reply", rep, rows[i].exp);
      check("float after frame", {15'h0, sdo_oe}, 16'h0000);
    end
    cyc(1);
    temp = 8'h82;
    cyc(3);
    temp = 8'h50;
    check("overtemp", {13'h0, status[FLAG_OVERTEMP], fail, gde}, 16'h0006);
    m.xfer({48'h0, 16'h5f00}, 16, rep);
    check("clear reply", rep, 16'hf0e0);
    check("stay silent", {7'h0, status, fail}, 16'h01c1);
    cyc(1);
    sup_low = 1'b1;
    cyc(1);
    sup_low  = 1'b0;
    sup_high = 1'b1;
    cyc(1);
    sup_high = 1'b0;
    cyc(2);
    check("supply flags", {8'h0, status}, 16'h00ec);
    out_win = 2'b10;
    cyc(1200);
    check("filter hold", {15'h0, status[FLAG_OUT_ONE]}, 16'h0001);
    cyc(100);
    check("filter drop", {8'h0, status}, 16'h006c);
    out_win  = 2'b11;
    off_mode = 1'b1;
    gate_win = 1'b0;
    cyc(5);
    check("off clears", {7'h0, status, fail}, 16'h0000);
    off_mode = 1'b0;
    cyc(60);
    check("late gate", {7'h0, status, fail}, 16'h0003);
    check("no drive", {15'h0, gde}, 16'h0000);
    m.xfer({48'h0, 16'hc600}, 16, rep);
    check("after off", rep, 16'h0000);
    cyc(1);
    off_mode = 1'b1;
    cyc(3);
    gate_win = 1'b1;
    off_mode = 1'b0;
    cyc(20);
    check("gate good", {7'h0, status, fail}, 16'h0040);
    gate_win = 1'b0;
    cyc(3);
    check("gate lost", {6'h0, status, fail, gde}, 16'h0002);
    // mid-run reset back to idle, first reply zero again
    reset_n = 1'b0;
    cyc(4);
    check("reset again", {6'h00, status, fail, sdo_oe}, 16'h0000);
    reset_n = 1'b1;
    cyc(20);
    m.xfer({48'h0, 16'hc600}, 16, rep);
    check("first after reset", rep, 16'h0000);
    wrap_up();
  end
endmodule
